// file: hdl/ctc_transceiver_control.sv
// ctc_transceiver_control: digital control of a high-speed CAN transceiver,
// with an event FIFO read over a plain register port.
// assumes the controller tx line is on i_mclk; pins and supply flags are async.
//
// Contract
// - drive bus dominant while tx input low, recessive while high
// - any node's dominant beats recessive on the observed bus
// - normal mode: rx output low on dominant bus, high on recessive
// - normal mode: tx stuck low past time-out disables drivers until tx high
// - both detectors time out after nominal 1.25 ms
// - standby: bus stuck dominant forces rx high until bus recessive
// - standby select picks normal or standby, undriven means standby
// - standby turns off transmitter and high-speed receiver
// - after supplies valid, drivers stay off until tx seen high
// - transceiver undervoltage returns bus outputs to high impedance
// - normal mode: undervoltage forces rx output high
// - low-power receiver enabled once both supplies valid, then stays
// - over-temperature disables only the bus drivers
// - tx input defaults high so bus defaults recessive
`timescale 1ns/1ps
`default_nettype none

module ctc_fifo #(
  parameter int WIDTH = 4,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             i_mclk,
  input  wire logic             i_rst_n,
  input  wire logic             i_ce,
  // write side
  input  wire logic             i_in_valid,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_in_ready,
  // read side
  output logic                  o_out_valid,
  output logic [WIDTH-1:0]      o_out_data,
  input  wire logic             i_out_ready
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW-1:0]    wr_ptr_reg;
  logic [PW-1:0]    rd_ptr_reg;
  logic [PW:0]      count_reg;
  logic             push;
  logic             pop;

  // honest full and empty straight from the count
  assign o_in_ready  = (count_reg != (PW+1)'(DEPTH));
  assign o_out_valid = (count_reg != '0);
  assign o_out_data  = mem_reg[rd_ptr_reg];
  assign push        = i_ce && i_in_valid && o_in_ready;
  assign pop         = i_ce && i_out_ready && o_out_valid;

  // storage, one flop row per entry
  always_ff @(posedge i_mclk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= i_in_data;
    end
  end

  // pointers and occupancy
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == PW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == PW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule // ctc_fifo

module ctc_transceiver_control
  import ctc_pkg::*;
#(
  parameter logic [CNT_W-1:0] P_PD_TIMEOUT_CYC = CNT_W'(PD_TIMEOUT_CYC)
) (
  // clock, reset, enable
  input  wire logic              i_mclk,
  input  wire logic              i_rst_n,
  input  wire logic              i_ce,
  // protocol controller side
  input  wire logic              i_controller_tx_out,
  output logic                   o_controller_rx_in,
  // bus pin: observed level, drive level, drive enable
  input  wire logic              i_bus_dom,
  output logic                   o_bus_dom,
  output logic                   o_bus_oe,
  // mode pin and supervisors
  input  wire logic              i_standby_select,
  input  wire logic              i_transceiver_supply_ok,
  input  wire logic              i_io_supply_ok,
  input  wire logic              i_over_temp,
  // receiver enables
  output logic                   o_hs_rx_en,
  output logic                   o_lp_rx_en,
  // register port
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [DATA_W-1:0] i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  output logic [DATA_W-1:0]      o_rdata
);
  logic [SY_N-1:0]  sync1_reg;
  logic [SY_N-1:0]  sync2_reg;
  logic             standby_select_s, bus_s, transceiver_supply_ok_s, vio_s, ot_s;
  logic [1:0]       ctrl_reg;
  ctc_mode_e        mode_reg;
  logic             armed_reg;
  logic [CNT_W-1:0] txd_cnt_reg;
  logic [CNT_W-1:0] bus_cnt_reg;
  logic             txd_to_reg;
  logic             bus_to_reg;
  logic             bus_obs;
  logic             drv_en_next;
  logic             rx_next;
  logic [EVT_W-1:0] evt_pend_reg;
  logic [EVT_W-1:0] evt_new;
  logic [EVT_W-1:0] prev_reg;
  logic [EVT_W-1:0] cur_flags;
  logic             fifo_in_ready;
  logic             fifo_out_valid;
  logic [EVT_W-1:0] fifo_out_data;
  logic             evt_pop;

  // two-flop synchronisers, one lane per async input
  for (genvar g = 0; g < SY_N; g++) begin : g_sync
    always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
        sync1_reg[g] <= SY_RESET[g];   // standby lane resets high, like its pull-up
        sync2_reg[g] <= SY_RESET[g];
      end else if (i_ce) begin
        sync1_reg[g] <= (g == SY_STANDBY_SELECT) ? i_standby_select :
                        (g == SY_BUS)  ? i_bus_dom :
                        (g == SY_TRANSCEIVER_SUPPLY_OK) ? i_transceiver_supply_ok :
                        (g == SY_VIO)  ? i_io_supply_ok : i_over_temp;
        sync2_reg[g] <= sync1_reg[g];
      end
    end
  end
  assign standby_select_s = sync2_reg[SY_STANDBY_SELECT];
  assign bus_s  = sync2_reg[SY_BUS];
  assign transceiver_supply_ok_s = sync2_reg[SY_TRANSCEIVER_SUPPLY_OK];
  assign vio_s  = sync2_reg[SY_VIO];
  assign ot_s   = sync2_reg[SY_OT];

  // our own dominant drive counts even before the comparator sees it
  assign bus_obs = bus_s || o_bus_dom;

  // mode select from pin or software override
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      mode_reg <= MODE_STANDBY;
    end else if (i_ce) begin
      mode_reg <= (standby_select_s || ctrl_reg[CTRL_SW_STANDBY_SELECT]) ? MODE_STANDBY : MODE_NORMAL;
    end
  end

  // driver arming: needs both supplies and tx seen high; brown-out disarms
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      armed_reg <= 1'b0;
    end else if (i_ce) begin
      if (!transceiver_supply_ok_s) begin
        armed_reg <= 1'b0;
      end else if (vio_s && i_controller_tx_out) begin
        armed_reg <= 1'b1;
      end
    end
  end

  // tx permanent-dominant counter, restarts on each recessive sample
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      txd_cnt_reg <= '0;
      txd_to_reg  <= 1'b0;
    end else if (i_ce) begin
      if (i_controller_tx_out) begin
        txd_cnt_reg <= '0;
        txd_to_reg  <= 1'b0;
      end else if (mode_reg == MODE_NORMAL && !txd_to_reg) begin
        if (txd_cnt_reg == P_PD_TIMEOUT_CYC - 1'b1) begin
          txd_to_reg <= 1'b1;
        end else begin
          txd_cnt_reg <= txd_cnt_reg + 1'b1;
        end
      end
    end
  end

  // bus permanent-dominant counter, only armed in standby
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      bus_cnt_reg <= '0;
      bus_to_reg  <= 1'b0;
    end else if (i_ce) begin
      if (!bus_s) begin
        bus_cnt_reg <= '0;
        bus_to_reg  <= 1'b0;
      end else if (mode_reg == MODE_STANDBY && !bus_to_reg) begin
        if (bus_cnt_reg == P_PD_TIMEOUT_CYC - 1'b1) begin
          bus_to_reg <= 1'b1;
        end else begin
          bus_cnt_reg <= bus_cnt_reg + 1'b1;
        end
      end
    end
  end

  // driver gating; of the pin outputs, thermal trip touches only the drivers
  assign drv_en_next = (mode_reg == MODE_NORMAL) && armed_reg && transceiver_supply_ok_s
                       && !ot_s && !txd_to_reg;

  // receive data per mode
  always_comb begin
    case (mode_reg)
      MODE_NORMAL:  rx_next = transceiver_supply_ok_s ? !bus_obs : 1'b1;
      MODE_STANDBY: rx_next = (o_lp_rx_en && !bus_to_reg) ? !bus_s : 1'b1;
      default:      rx_next = 1'b1;
    endcase
  end

  // registered pin outputs; reset leaves the bus recessive and undriven
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_bus_dom          <= 1'b0;
      o_bus_oe           <= 1'b0;
      o_controller_rx_in <= 1'b1;
      o_hs_rx_en         <= 1'b0;
    end else if (i_ce) begin
      o_bus_dom          <= drv_en_next && !i_controller_tx_out;
      o_bus_oe           <= drv_en_next;
      o_controller_rx_in <= rx_next;
      o_hs_rx_en         <= (mode_reg == MODE_NORMAL);
    end
  end

  // low-power receiver latches on once both supplies were valid
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_lp_rx_en <= 1'b0;
    end else if (i_ce && transceiver_supply_ok_s && vio_s) begin
      o_lp_rx_en <= 1'b1;
    end
  end

  // fault event capture; pending bits wait while the fifo is full
  assign cur_flags = {ot_s, !transceiver_supply_ok_s, bus_to_reg, txd_to_reg};
  assign evt_new   = cur_flags & ~prev_reg;
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      prev_reg     <= EVT_W'(1 << EV_UV);  // supply lane resets low: no false undervoltage event
      evt_pend_reg <= '0;
    end else if (i_ce) begin
      prev_reg <= cur_flags;
      // a new edge in the push cycle is kept, not dropped
      if (evt_pend_reg != '0 && fifo_in_ready) begin
        evt_pend_reg <= evt_new & {EVT_W{ctrl_reg[CTRL_LOG_EN]}};
      end else begin
        evt_pend_reg <= evt_pend_reg | (evt_new & {EVT_W{ctrl_reg[CTRL_LOG_EN]}});
      end
    end
  end

  ctc_fifo #(
    .WIDTH (EVT_W),
    .DEPTH (FIFO_DEPTH)
  ) u_evt_fifo (
    .i_mclk      (i_mclk),
    .i_rst_n     (i_rst_n),
    .i_ce        (i_ce),
    .i_in_valid  (evt_pend_reg != '0),
    .i_in_data   (evt_pend_reg),
    .o_in_ready  (fifo_in_ready),
    .o_out_valid (fifo_out_valid),
    .o_out_data  (fifo_out_data),
    .i_out_ready (evt_pop)
  );

  // reading the event register pops one entry
  assign evt_pop = i_rd && (i_addr == REG_EVENT);

  // control register writes
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      ctrl_reg <= CTRL_RESET;
    end else if (i_ce && i_wr && i_addr == REG_CTRL) begin
      ctrl_reg <= i_wdata[1:0];
    end
  end

  // read data, one cycle after the strobe; unmapped reads zero
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_rdata <= '0;
    end else if (i_ce && i_rd) begin
      case (i_addr)
        REG_CTRL:   o_rdata <= {30'h0, ctrl_reg};
        REG_STATUS: o_rdata <= {24'h0, o_lp_rx_en, ot_s, vio_s, transceiver_supply_ok_s,
                                bus_to_reg, txd_to_reg, armed_reg, mode_reg == MODE_STANDBY};
        REG_EVENT:  o_rdata <= {23'h0, fifo_out_valid, 4'h0, fifo_out_valid ? fifo_out_data : 4'h0};  // empty reads zero
        default:    o_rdata <= '0;
      endcase
    end
  end

  // checks on the driven side
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n || !i_ce);

  sequence por_tx_low;
    !armed_reg && !i_controller_tx_out;
  endsequence
  sequence tx_stuck;
    txd_to_reg && !i_controller_tx_out;
  endsequence

  tx_drive_a: assert property (o_bus_dom |-> $past(!i_controller_tx_out) && o_bus_oe)
    else $error("dominant drive without tx low");
  rx_normal_a: assert property ($past(mode_reg == MODE_NORMAL && transceiver_supply_ok_s) |->
    o_controller_rx_in == $past(!bus_obs))
    else $error("rx does not follow bus");
  tx_timeout_a: assert property (tx_stuck |=> !o_bus_oe)
    else $error("driver on after tx time-out");
  tx_release_a: assert property (txd_to_reg && i_controller_tx_out |=> !txd_to_reg)
    else $error("tx time-out not released");
  count_term_a: assert property ($rose(txd_to_reg) |->
    $past(txd_cnt_reg) == P_PD_TIMEOUT_CYC - 1'b1)
    else $error("time-out at wrong count");
  bus_latch_a: assert property (bus_to_reg && mode_reg == MODE_STANDBY |=> o_controller_rx_in)
    else $error("rx not held high on bus time-out");
  standby_off_a: assert property (mode_reg == MODE_STANDBY |=> !o_bus_oe && !o_hs_rx_en)
    else $error("transmitter on in standby");
  por_arm_a: assert property (por_tx_low |=> !o_bus_oe)
    else $error("driver on before tx high");
  brown_out_a: assert property (!transceiver_supply_ok_s |=> !o_bus_oe && !armed_reg)
    else $error("driver on in undervoltage");
  uv_rx_a: assert property (mode_reg == MODE_NORMAL && !transceiver_supply_ok_s |=> o_controller_rx_in)
    else $error("rx not recessive in undervoltage");
  lp_keep_a: assert property (o_lp_rx_en |=> o_lp_rx_en)
    else $error("low-power receiver dropped");
  hot_off_a: assert property (ot_s |=> !o_bus_oe)
    else $error("driver on while over temperature");
  // timers, drive, receivers and mode follow their inputs on every enabled cycle
  tx_timer_a: assert property (i_controller_tx_out |=> !txd_to_reg && txd_cnt_reg == '0)
    else $error("tx timer not restarted");
  bus_timer_a: assert property (!bus_s |=> !bus_to_reg && bus_cnt_reg == '0)
    else $error("bus timer not restarted");
  tx_recessive_a: assert property (i_controller_tx_out |=> !o_bus_dom)
    else $error("dominant drive with tx high");
  hs_normal_a: assert property (mode_reg == MODE_NORMAL |=> o_hs_rx_en)
    else $error("high-speed receiver off in normal");
  lp_wait_a: assert property (!o_lp_rx_en && !(transceiver_supply_ok_s && vio_s) |=> !o_lp_rx_en)
    else $error("low-power receiver on before supplies");
  pin_standby_select_a: assert property (standby_select_s |=> mode_reg == MODE_STANDBY)
    else $error("standby pin ignored");
endmodule // ctc_transceiver_control

`default_nettype wire

// file: include/ctc_pkg.sv
// ctc_pkg: constants shared by the transceiver control logic.
// assumes a 125 MHz device clock and a 4-bit byte-addressed register port.
`default_nettype none

package ctc_pkg;

  // clock and permanent-dominant timing
  localparam int CLK_PERIOD_NS  = 8;
  localparam int PD_TIMEOUT_NS  = 1250000;                     // 1.25 ms nominal
  localparam int PD_TIMEOUT_CYC = PD_TIMEOUT_NS / CLK_PERIOD_NS;
  localparam int CNT_W          = 18;

  // register port layout
  localparam int          ADDR_W     = 4;
  localparam int          DATA_W     = 32;
  localparam logic [3:0]  REG_CTRL   = 4'h0;
  localparam logic [3:0]  REG_STATUS = 4'h4;
  localparam logic [3:0]  REG_EVENT  = 4'h8;

  // control register fields and reset value
  localparam int          CTRL_LOG_EN   = 0;
  localparam int          CTRL_SW_STANDBY_SELECT  = 1;
  localparam logic [1:0]  CTRL_RESET    = 2'h1;

  // event word bits
  localparam int EVT_W     = 4;
  localparam int EV_TXD_TO = 0;
  localparam int EV_BUS_TO = 1;
  localparam int EV_UV     = 2;
  localparam int EV_OT     = 3;
  localparam int FIFO_DEPTH = 8;
  localparam int EVT_VALID  = 8;

  // synchroniser lanes and their reset value (standby pulled up)
  localparam int         SY_STANDBY_SELECT  = 0;
  localparam int         SY_BUS   = 1;
  localparam int         SY_TRANSCEIVER_SUPPLY_OK  = 2;
  localparam int         SY_VIO   = 3;
  localparam int         SY_OT    = 4;
  localparam int         SY_N     = 5;
  localparam logic [4:0] SY_RESET = 5'h01;

  typedef enum logic {MODE_NORMAL, MODE_STANDBY} ctc_mode_e;

endpackage : ctc_pkg

`default_nettype wire

// file: test/ctc_bus_model.sv
// ctc_bus_model: wired bus seen by the transceiver, with one other node on it.
// assumes the node's drive level only counts while its driver enable is high.
`timescale 1ns/1ps
`default_nettype none

module ctc_bus_model (
  // our node's drivers
  input  wire logic i_node_dom,
  input  wire logic i_node_oe,
  // another node asserting dominant
  input  wire logic i_other_dom,
  // observed bus level, 1 = dominant
  output logic      o_bus_dom
);
  // dominant from any node wins; a released bus is held recessive by termination
  assign o_bus_dom = (i_node_oe & i_node_dom) | i_other_dom;
endmodule // ctc_bus_model

`default_nettype wire

// file: test/ctc_transceiver_control_bench.sv
// ctc_transceiver_control_bench: directed pin and register tests of the transceiver control.
// assumes a shortened time-out parameter so stuck-dominant cases finish quickly.
`timescale 1ns/1ps
`default_nettype none

module ctc_transceiver_control_bench
  import ctc_pkg::*;
;
  localparam int P = 20;
  logic i_mclk = 1'b0, i_rst_n = 1'b0, i_ce = 1'b1, tx = 1'b0, standby_select = 1'b0, vdd_ok = 1'b1, vio_ok = 1'b1;
  logic ot = 1'b0, other = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
  logic [ADDR_W-1:0] i_addr = '0;
  logic [DATA_W-1:0] i_wdata = '0, o_rdata, d;
  logic rx, bus, drv, oe, hs, lp;
  int mismatches = 0, n_compared = 0, cycles = 0, nvalid;

  ctc_transceiver_control #(.P_PD_TIMEOUT_CYC(18'(P))) dut_u (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_controller_tx_out(tx), .o_controller_rx_in(rx),
    .i_bus_dom(bus), .o_bus_dom(drv), .o_bus_oe(oe), .i_standby_select(standby_select),
    .i_transceiver_supply_ok(vdd_ok), .i_io_supply_ok(vio_ok), .i_over_temp(ot),
    .o_hs_rx_en(hs), .o_lp_rx_en(lp), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata));

  ctc_bus_model bus_u (.i_node_dom(drv), .i_node_oe(oe), .i_other_dom(other), .o_bus_dom(bus));

  // free-running clock, 8 ns period
  always #4 i_mclk = ~i_mclk;

  // hang guard, well above the few hundred cycles the tests need
  always @(posedge i_mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches = mismatches + 1;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_compared = n_compared + 1;
    if (got !== exp) begin
      mismatches = mismatches + 1;
      $display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  // wait n edges, then settle just past the last one
  task automatic cyc(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge i_mclk);
    i_wr <= 1'b1; i_addr <= a; i_wdata <= v;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask

  // read data stands from the cycle after the strobe until the next read
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge i_mclk);
    i_rd <= 1'b1; i_addr <= a;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1 v = o_rdata;
  endtask

  // pins change just after an edge
  task automatic pin(input string which, input logic v);
    @(posedge i_mclk);
    case (which)
      "tx": tx <= v;
      "standby_select": standby_select <= v;
      "vdd": vdd_ok <= v;
      "ot": ot <= v;
      default: other <= v;
    endcase
  endtask

  task automatic tally_and_finish();
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    // tx low at power-up keeps drivers off until it rises
    cyc(8); chk(oe, 1'b0, "oe with tx low at arming");
    pin("tx", 1'b1); cyc(5); chk(oe, 1'b1, "oe after tx high");
    chk(hs, 1'b1, "hs rx in normal");
    chk(lp, 1'b1, "lp rx with supplies ok");
    chk(rx, 1'b1, "rx recessive idle");
    pin("tx", 1'b0); cyc(2); chk(drv, 1'b1, "drive dominant on tx low");
    cyc(4); chk(rx, 1'b0, "rx low on dominant bus");
    pin("tx", 1'b1); cyc(5); chk(drv, 1'b0, "recessive on tx high");
    chk(rx, 1'b1, "rx high on recessive bus");
    pin("other", 1'b1); cyc(5); chk(rx, 1'b0, "foreign dominant wins");
    pin("other", 1'b0); $display("test pins done");
    // tx stuck low: drivers survive short of the count, drop past it
    pin("tx", 1'b0); cyc(P - 4); chk(oe, 1'b1, "oe before time-out");
    cyc(8); chk(oe, 1'b0, "oe after tx time-out");
    pin("tx", 1'b1); cyc(4); chk(oe, 1'b1, "oe back after tx high");
    $display("test tx timeout done");
    // brown-out of the transceiver supply
    pin("vdd", 1'b0); cyc(5); chk(oe, 1'b0, "oe under undervoltage");
    chk(rx, 1'b1, "rx forced recessive under undervoltage");
    pin("vdd", 1'b1); cyc(5); chk(oe, 1'b1, "oe after supply back");
    // over temperature: only the drivers stop
    pin("ot", 1'b1); cyc(5); chk(oe, 1'b0, "oe off in over temp");
    pin("other", 1'b1); cyc(5); chk(rx, 1'b0, "rx still works in over temp");
    pin("other", 1'b0); pin("ot", 1'b0); cyc(5); chk(oe, 1'b1, "oe after over temp");
    $display("test supply and thermal done");
    // standby: bus stuck dominant forces rx high until bus recessive
    pin("standby_select", 1'b1); cyc(5); chk(hs, 1'b0, "hs rx off in standby");
    chk(oe, 1'b0, "transmitter off in standby");
    pin("other", 1'b1); cyc(6); chk(rx, 1'b0, "wake receive of dominant");
    cyc(P + 4); chk(rx, 1'b1, "rx forced after bus time-out");
    pin("other", 1'b0); cyc(6); chk(rx, 1'b1, "rx recessive after release");
    pin("other", 1'b1); cyc(6); chk(rx, 1'b0, "wake-up re-armed");
    pin("other", 1'b0); pin("standby_select", 1'b0); cyc(5); chk(hs, 1'b1, "back to normal");
    $display("test standby done");
    // register port
    rd(REG_CTRL, d); chk(d, 32'h0000_0001, "ctrl reset value");
    wr(REG_CTRL, 32'h0000_0002); rd(REG_CTRL, d); chk(d, 32'h0000_0002, "ctrl written");
    cyc(4); chk(hs, 1'b0, "software standby");
    wr(REG_CTRL, 32'h0000_0001); wr(REG_STATUS, 32'hFFFF_FFFF);
    rd(REG_STATUS, d); chk({28'h0, d[5:4], d[0], d[6]}, 32'h0000_000C, "status supplies and mode");
    rd(4'hC, d); chk(d, 32'h0000_0000, "unmapped read");
    rd(REG_CTRL, d); chk(d, 32'h0000_0001, "ctrl after status write");
    $display("test registers done");
    // clock enable low freezes the tx timer and the drive outputs
    @(posedge i_mclk); i_ce <= 1'b0;
    pin("tx", 1'b0); cyc(P + 4); chk(oe, 1'b1, "oe kept while frozen");
    chk(drv, 1'b0, "drive frozen while disabled");
    pin("tx", 1'b1); i_ce <= 1'b1; cyc(4); chk(oe, 1'b1, "oe after enable back");
    $display("test clock enable done");
    // event fifo: logged faults in the order they happened, then empty
    rd(REG_EVENT, d); chk(d, 32'h0000_0101, "tx time-out event");
    rd(REG_EVENT, d); chk(d, 32'h0000_0104, "undervoltage event");
    rd(REG_EVENT, d); chk(d, 32'h0000_0108, "over temp event");
    rd(REG_EVENT, d); chk(d, 32'h0000_0102, "bus time-out event");
    rd(REG_EVENT, d); chk(d, 32'h0000_0000, "event fifo empty");
    // logging off: an over-temp edge leaves no event
    wr(REG_CTRL, 32'h0000_0000); pin("ot", 1'b1); cyc(4); pin("ot", 1'b0); cyc(4);
    rd(REG_EVENT, d); chk(d, 32'h0000_0000, "no event with logging off");
    wr(REG_CTRL, 32'h0000_0001);
    // overfill with over-temp edges, then drain
    for (int i = 0; i < 10; i++) begin
      pin("ot", 1'b1); cyc(4); pin("ot", 1'b0); cyc(4);
    end
    nvalid = 0;
    for (int i = 0; i < 12; i++) begin
      rd(REG_EVENT, d);
      if (d[8] === 1'b1) begin
        nvalid = nvalid + 1;
        chk(d[3:0], 4'h8, "event mask over temp");
      end
    end
    chk(nvalid, 9, "fifo full then one merged word");
    $display("test event fifo done");
    tally_and_finish();
  end
endmodule // ctc_transceiver_control_bench

`default_nettype wire
